// file: src/reactive_undervoltage_decoupling.v
// Decoupling decision logic with reclose release and Avalon-MM settings.
// Assumes all measurement inputs come from logic on sys_clk; only the
// remote release input arrives from a pin and is synchronised here.
//
// The implementer's own choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
`include "qv_decoupling_defines.vh"
module reactive_undervoltage_decoupling #(
    parameter [32:0] T1_CYC = `T1_MS * (`CLK_HZ / 1000),
    parameter [32:0] T2_CYC = `T2_MS * (`CLK_HZ / 1000),
    parameter [32:0] TREC_CYC = 33'd6000000000,
    parameter TRIG_W = 16
) (
    input wire sys_clk,
    input wire rst,
    input wire [7:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output wire avs_waitrequest,
    input wire signed [15:0] positive_seq_reactive_power,
    input wire [15:0] positive_seq_current,
    input wire [15:0] power_angle,
    input wire [15:0] v_ab,
    input wire [15:0] v_bc,
    input wire [15:0] v_ca,
    input wire [15:0] freq_mhz,
    input wire [TRIG_W-1:0] ext_trip_in,
    input wire remote_release_input,
    output reg unit_trip,
    output reg pcc_trip,
    output reg reclose_release
);
    // ------------------------------------------------------------------
    // Settings registers
    // ------------------------------------------------------------------
    reg [15:0] ctrl_q;
    reg [15:0] angle_lim_q;
    reg [15:0] min_current_threshold_q;
    reg [15:0] reactive_power_threshold_q;
    reg [15:0] uv_lim_q;
    reg [15:0] reclose_voltage_threshold_q;
    reg [15:0] fmin_q;
    reg [15:0] fmax_q;
    reg [15:0] trig_mask_q;
    reg ack_q;
    reg rem_s1_q;
    reg rem_s2_q;
    reg gen_tripped_q;
    reg pcc_tripped_q;
    reg block_q;
    reg recovered_q;
    reg trip_prev_q;
    wire module_enable;
    wire decoupling_method_select;
    wire imin_enable;
    wire external_release_enable;
    wire [15:0] v_max;
    wire [15:0] v_min;
    wire undervoltage;
    wire q_drawn;
    wire react_ok;
    wire imin_ok;
    wire imin_applied;
    wire pickup;
    wire t1_done;
    wire t2_done;
    wire rec_done;
    wire any_trip;
    wire trip_rise;
    wire freq_ok;
    wire volt_ok;
    wire release_cond;

    // Returns the larger or smaller of two magnitudes
    function [15:0] pick;
        input [15:0] a;
        input [15:0] b;
        input want_max;
        begin
            if (want_max)
                pick = (a > b) ? a : b;
            else
                pick = (a < b) ? a : b;
        end
    endfunction

    // Byte-lane merge for a 16-bit setting
    function [15:0] merge;
        input [15:0] old;
        input [31:0] wd;
        input [3:0] be;
        begin
            merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
        end
    endfunction

    assign module_enable = ctrl_q[`CTRL_ENABLE];
    assign decoupling_method_select = ctrl_q[`CTRL_METHOD];
    assign imin_enable = ctrl_q[`CTRL_IMIN_EN];
    assign external_release_enable = ctrl_q[`CTRL_EXT_REL];

    // ------------------------------------------------------------------
    // Avalon-MM slave
    // ------------------------------------------------------------------
    // One wait cycle per access; answer lands on the second edge
    assign avs_waitrequest = (avs_read || avs_write) && !ack_q;

    always @(posedge sys_clk) begin
        if (rst)
            ack_q <= 1'b0;
        else
            ack_q <= (avs_read || avs_write) && !ack_q;
    end

    // Settings writes, taken on the edge after the one that ends waitrequest
    always @(posedge sys_clk) begin
        if (rst) begin
            ctrl_q <= `RST_CTRL;
            angle_lim_q <= `RST_ANGLE_LIM;
            min_current_threshold_q <= `RST_IMIN;
            reactive_power_threshold_q <= `RST_QMIN;
            uv_lim_q <= `RST_UV_LIM;
            reclose_voltage_threshold_q <= `RST_VREL;
            fmin_q <= `RST_FMIN;
            fmax_q <= `RST_FMAX;
            trig_mask_q <= `RST_TRIG_MASK;
        end else if (avs_write && ack_q) begin
            case (avs_address)
                `ADDR_CTRL: ctrl_q <= merge(ctrl_q, avs_writedata,
                    avs_byteenable) & 16'h000f;
                `ADDR_ANGLE_LIM: angle_lim_q <= merge(angle_lim_q,
                    avs_writedata, avs_byteenable);
                `ADDR_IMIN: min_current_threshold_q <= merge(
                    min_current_threshold_q, avs_writedata, avs_byteenable);
                `ADDR_QMIN: reactive_power_threshold_q <= merge(
                    reactive_power_threshold_q, avs_writedata,
                    avs_byteenable);
                `ADDR_UV_LIM: uv_lim_q <= merge(uv_lim_q, avs_writedata,
                    avs_byteenable);
                `ADDR_VREL: reclose_voltage_threshold_q <= merge(
                    reclose_voltage_threshold_q, avs_writedata,
                    avs_byteenable);
                `ADDR_FMIN: fmin_q <= merge(fmin_q, avs_writedata,
                    avs_byteenable);
                `ADDR_FMAX: fmax_q <= merge(fmax_q, avs_writedata,
                    avs_byteenable);
                `ADDR_TRIG_MASK: trig_mask_q <= merge(trig_mask_q,
                    avs_writedata, avs_byteenable);
                default: ;
            endcase
        end
    end

    // Read data registered; unmapped addresses read zero
    always @(posedge sys_clk) begin
        if (rst)
            avs_readdata <= 32'h00000000;
        else if (avs_read && !ack_q) begin
            case (avs_address)
                `ADDR_CTRL: avs_readdata <= {16'h0000, ctrl_q};
                `ADDR_ANGLE_LIM: avs_readdata <= {16'h0000, angle_lim_q};
                `ADDR_IMIN: avs_readdata <= {16'h0000,
                    min_current_threshold_q};
                `ADDR_QMIN: avs_readdata <= {16'h0000,
                    reactive_power_threshold_q};
                `ADDR_UV_LIM: avs_readdata <= {16'h0000, uv_lim_q};
                `ADDR_VREL: avs_readdata <= {16'h0000,
                    reclose_voltage_threshold_q};
                `ADDR_FMIN: avs_readdata <= {16'h0000, fmin_q};
                `ADDR_FMAX: avs_readdata <= {16'h0000, fmax_q};
                `ADDR_TRIG_MASK: avs_readdata <= {16'h0000, trig_mask_q};
                `ADDR_STATUS: avs_readdata <= {24'h000000, pickup,
                    block_q, pcc_tripped_q, gen_tripped_q, reclose_release,
                    pcc_trip, unit_trip, rec_done};
                default: avs_readdata <= 32'h00000000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Pickup decision
    // ------------------------------------------------------------------
    // Only line-to-line voltages are looked at, never phase-to-earth
    assign v_max = pick(pick(v_ab, v_bc, 1'b1), v_ca, 1'b1);
    assign v_min = pick(pick(v_ab, v_bc, 1'b0), v_ca, 1'b0);
    assign undervoltage = v_max < uv_lim_q;
    // Negative Q1 means reactive power drawn from the grid
    assign q_drawn = positive_seq_reactive_power < 16'sd0;
    assign react_ok = decoupling_method_select ?
        ((-positive_seq_reactive_power) >
         $signed({1'b0, reactive_power_threshold_q[14:0]}))
        : (q_drawn && (power_angle > angle_lim_q));
    assign imin_applied = !decoupling_method_select || imin_enable;
    assign imin_ok = !imin_applied ||
        (positive_seq_current > min_current_threshold_q);
    assign pickup = module_enable && undervoltage && q_drawn && react_ok &&
        imin_ok;

    // ------------------------------------------------------------------
    // Trip delays
    // ------------------------------------------------------------------
    // Both run from the same pickup level; its loss clears them
    delay_timer #(.WIDTH(33), .COUNT(T1_CYC)) t1_timer (
        .sys_clk(sys_clk),
        .rst(rst),
        .run(pickup),
        .expired(t1_done)
    );

    delay_timer #(.WIDTH(33), .COUNT(T2_CYC)) t2_timer (
        .sys_clk(sys_clk),
        .rst(rst),
        .run(pickup),
        .expired(t2_done)
    );

    // Trip outputs follow expiry while pickup stays
    always @(posedge sys_clk) begin
        if (rst) begin
            unit_trip <= 1'b0;
            pcc_trip <= 1'b0;
        end else begin
            unit_trip <= t1_done;
            pcc_trip <= t2_done;
        end
    end

    // ------------------------------------------------------------------
    // Recovery interval and reclose release
    // ------------------------------------------------------------------
    assign any_trip = unit_trip || pcc_trip ||
        |(ext_trip_in & trig_mask_q[TRIG_W-1:0]);
    assign trip_rise = any_trip && !trip_prev_q;

    // Generator trip latch; cleared by a new release or disable
    always @(posedge sys_clk) begin
        if (rst) begin
            gen_tripped_q <= 1'b0;
            pcc_tripped_q <= 1'b0;
            trip_prev_q <= 1'b0;
            rem_s1_q <= 1'b0;
            rem_s2_q <= 1'b0;
        end else begin
            trip_prev_q <= any_trip;
            rem_s1_q <= remote_release_input;
            rem_s2_q <= rem_s1_q;
            if (unit_trip)
                gen_tripped_q <= 1'b1;
            else if (reclose_release || !module_enable)
                gen_tripped_q <= 1'b0;
            // PCC latch cleared only by disabling: manual reclose path
            if (pcc_trip)
                pcc_tripped_q <= 1'b1;
            else if (!module_enable)
                pcc_tripped_q <= 1'b0;
        end
    end

    // Block set by a trip, cleared only when the timer runs out
    always @(posedge sys_clk) begin
        if (rst)
            block_q <= 1'b0;
        else if (trip_rise || any_trip)
            block_q <= 1'b1;
        else if (rec_done)
            block_q <= 1'b0;
    end

    // Recovery timer held clear while any trip is present; counts from its end
    delay_timer #(.WIDTH(33), .COUNT(TREC_CYC)) rec_timer (
        .sys_clk(sys_clk),
        .rst(rst),
        .run(block_q && !trip_rise && !any_trip),
        .expired(rec_done)
    );

    // Elapsed recovery is remembered until the next trip, so that the
    // release can still come when the conditions are met only later
    always @(posedge sys_clk) begin
        if (rst)
            recovered_q <= 1'b0;
        else if (any_trip)
            recovered_q <= 1'b0;
        else if (rec_done)
            recovered_q <= 1'b1;
    end

    assign freq_ok = (freq_mhz >= fmin_q) && (freq_mhz <= fmax_q);
    assign volt_ok = v_min > reclose_voltage_threshold_q;
    assign release_cond = external_release_enable ? rem_s2_q
        : (volt_ok && freq_ok);

    // Release needs a generator trip, no PCC trip, and the timer done
    always @(posedge sys_clk) begin
        if (rst)
            reclose_release <= 1'b0;
        else
            reclose_release <= module_enable && gen_tripped_q &&
                !pcc_tripped_q && recovered_q && release_cond;
    end
endmodule // reactive_undervoltage_decoupling

// file: src/qv_decoupling_defines.vh
// Constants for the reactive-power / undervoltage decoupling block.
// Assumes measurements arrive as per-unit fixed point numbers, signed for Q1 only,
// scaled so that 1024 means one nominal unit (In, Sn, Vn, 1 degree x 16).
`ifndef QV_DECOUPLING_DEFINES_VH
`define QV_DECOUPLING_DEFINES_VH

// ------------------------------------------------------------------
// Avalon-MM register offsets (byte addresses)
// ------------------------------------------------------------------
`define ADDR_CTRL 8'h00
`define ADDR_ANGLE_LIM 8'h04
`define ADDR_IMIN 8'h08
`define ADDR_QMIN 8'h0c
`define ADDR_UV_LIM 8'h10
`define ADDR_VREL 8'h14
`define ADDR_FMIN 8'h18
`define ADDR_FMAX 8'h1c
`define ADDR_TRIG_MASK 8'h20
`define ADDR_STATUS 8'h24

// ------------------------------------------------------------------
// Control field positions
// ------------------------------------------------------------------
`define CTRL_ENABLE 0
`define CTRL_METHOD 1
`define CTRL_IMIN_EN 2
`define CTRL_EXT_REL 3

// ------------------------------------------------------------------
// Reset values (1024 = 1.0 per unit, angle 16 = 1 degree, f in mHz)
// ------------------------------------------------------------------
`define RST_CTRL 16'h0000
`define RST_ANGLE_LIM 16'h0030
`define RST_IMIN 16'h0066
`define RST_QMIN 16'h0033
`define RST_UV_LIM 16'h0366
`define RST_VREL 16'h03cd
`define RST_FMIN 16'hb98c
`define RST_FMAX 16'hc382
`define RST_TRIG_MASK 16'hffff

// ------------------------------------------------------------------
// Timing in milliseconds and the 10 MHz clock rate
// ------------------------------------------------------------------
`define CLK_HZ 10000000
`define T1_MS 500
`define T2_MS 1500
`define TREC_MS 600000

`endif

// file: src/delay_timer.v
// Delay timer used for both trip delays and the recovery interval.
// Assumes run is a level; dropping it clears the count.
`timescale 1ns/1ps
module delay_timer #(
    parameter WIDTH = 33,
    parameter [WIDTH-1:0] COUNT = 33'd1
) (
    input wire sys_clk,
    input wire rst,
    input wire run,
    output wire expired
);
    reg [WIDTH-1:0] cnt_q;
    reg [WIDTH-1:0] cnt_d;

    // Count up while running, saturate at the terminal value
    always @* begin
        cnt_d = cnt_q;
        if (!run)
            cnt_d = {WIDTH{1'b0}};
        else if (cnt_q != COUNT)
            cnt_d = cnt_q + {{(WIDTH-1){1'b0}}, 1'b1};
    end

    always @(posedge sys_clk) begin
        if (rst)
            cnt_q <= {WIDTH{1'b0}};
        else
            cnt_q <= cnt_d;
    end

    assign expired = run && (cnt_q == COUNT);
endmodule // delay_timer

// file: bench/qv_decoupling_assertions.sv
// Checker for the decoupling block, watching trip and release ports.
// Assumes it is bound into the block with the same timer parameters.
`timescale 1ns/1ps
module qv_decoupling_assertions #(
    parameter [32:0] T1_CYC = 33'd1,
    parameter [32:0] T2_CYC = 33'd2,
    parameter [32:0] TREC_CYC = 33'd3,
    parameter TRIG_W = 16
) (
    input wire sys_clk,
    input wire rst,
    input wire [TRIG_W-1:0] ext_trip_in,
    input wire unit_trip,
    input wire pcc_trip,
    input wire reclose_release
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    wire any_trip = unit_trip | pcc_trip | (|ext_trip_in);
    logic [32:0] on_q, idle_q;
    logic gen_q;
    // Unit trip run length, quiet time since last trip, generator seen
    always @(posedge sys_clk) begin
        if (rst) begin
            on_q <= 33'h0;
            idle_q <= 33'h0;
            gen_q <= 1'b0;
        end else begin
            on_q <= unit_trip ? on_q + 33'h1 : 33'h0;
            idle_q <= any_trip ? 33'h0 : idle_q + 33'h1;
            gen_q <= gen_q | unit_trip;
        end
    end
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    property p_release_needs_gen;
        $rose(reclose_release) |-> gen_q;
    endproperty
    a_release_needs_gen: assert property (p_release_needs_gen)
        else $error("release without generator trip");
    property p_release_after_recovery;
        $rose(reclose_release) |-> idle_q >= TREC_CYC;
    endproperty
    a_release_after_recovery: assert property (p_release_after_recovery)
        else $error("release before recovery time");
    property p_no_release_in_trip;
        (unit_trip || pcc_trip) |-> ##2 !reclose_release;
    endproperty
    a_no_release_in_trip: assert property (p_no_release_in_trip)
        else $error("release while tripped");
    property p_pcc_after_unit;
        $rose(pcc_trip) |-> on_q == T2_CYC - T1_CYC;
    endproperty
    a_pcc_after_unit: assert property (p_pcc_after_unit)
        else $error("pcc trip spacing wrong");
    property p_trips_nested;
        pcc_trip |-> unit_trip;
    endproperty
    a_trips_nested: assert property (p_trips_nested)
        else $error("pcc trip without unit trip");
    property p_trips_drop_together;
        $fell(unit_trip) |-> !pcc_trip;
    endproperty
    a_trips_drop_together: assert property (p_trips_drop_together)
        else $error("pcc trip outlived unit trip");
    property p_pcc_inhibits;
        $rose(pcc_trip) |=> !reclose_release [*8];
    endproperty
    a_pcc_inhibits: assert property (p_pcc_inhibits)
        else $error("release after pcc trip");
    property p_reset_quiet;
        $fell(rst) |-> !unit_trip && !pcc_trip && !reclose_release;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet)
        else $error("outputs active after reset");
    c_unit: cover property ($rose(unit_trip));
    c_pcc: cover property ($rose(pcc_trip));
    c_release: cover property ($rose(reclose_release));
endmodule // qv_decoupling_assertions

// file: bench/remote_release_input_model.sv
// Far-end model: the PCC station answering with its remote release.
// Assumes grant is driven on sys_clk; the release is a level.
`timescale 1ns/1ps
module remote_release_input_model #(
    parameter DLY = 6
) (
    input wire sys_clk,
    input wire grant,
    input wire pcc_trip,
    output reg remote_release_input = 1'b0
);
    integer cnt_q = 0;
    // Station withholds release while its own breaker is open
    always @(posedge sys_clk) begin
        cnt_q <= (grant && !pcc_trip) ? cnt_q + 1 : 0;
        remote_release_input <= (cnt_q >= DLY);
    end
endmodule // remote_release_input_model

// file: bench/reactive_undervoltage_decoupling_test.sv
// Self-checking bench for the decoupling block with a PCC station model.
// Assumes shortened timers; thresholds stay at their reset values.
`timescale 1ns/1ps
`include "qv_decoupling_defines.vh"
module reactive_undervoltage_decoupling_test;
localparam [32:0] T1 = 33'd20;
localparam [32:0] T2 = 33'd40;
localparam [32:0] TR = 33'd100;
logic sys_clk, rst, avs_read, avs_write, avs_waitrequest, grant, remote;
logic unit_trip, pcc_trip, reclose_release;
logic [7:0] avs_address;
logic [3:0] avs_byteenable, c;
logic [31:0] avs_writedata, avs_readdata, rd;
logic signed [15:0] qr, q;
logic [15:0] ic, ang, vab, vbc, vca, fr, trip_in, i, a, v;
logic [15:0] exp_tab [0:10];
integer num_errors = 0, n_checks = 0, seed = 32'h1614, cyc = 0, n, k;
wire [2:0] outs = {reclose_release, pcc_trip, unit_trip};
reactive_undervoltage_decoupling #(.T1_CYC(T1), .T2_CYC(T2),
    .TREC_CYC(TR), .TRIG_W(16)) u_dut (.sys_clk(sys_clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .positive_seq_reactive_power(qr), .positive_seq_current(ic),
    .power_angle(ang), .v_ab(vab), .v_bc(vbc), .v_ca(vca),
    .freq_mhz(fr), .ext_trip_in(trip_in), .remote_release_input(remote),
    .unit_trip(unit_trip), .pcc_trip(pcc_trip),
    .reclose_release(reclose_release));
remote_release_input_model u_far (.sys_clk(sys_clk), .grant(grant),
    .pcc_trip(pcc_trip), .remote_release_input(remote));
initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
end
// Hang guard, well above the thousand or so cycles the run needs
always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
        num_errors++;
        results();
    end
end
task chk(input logic [32:0] seen, exp, input string msg);
    n_checks++;
    if (seen !== exp) begin
        num_errors++;
        $display("wrong value at %0t: %s %h/%h", $time, msg, seen, exp);
    end
endtask
task results;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
        $display("DONE - PASS");
    else
        $display("DONE - FAIL");
    $finish;
endtask
// One Avalon access, held until waitrequest is seen low
task bus(input logic wr, input logic [7:0] ad, input logic [31:0] d);
    integer t;
    t = 0;
    avs_address <= ad;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
        @(posedge sys_clk);
        t++;
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk);
endtask
task rchk(input logic [7:0] ad, input logic [31:0] e);
    bus(1'b0, ad, 32'h0);
    chk(rd, e, "register");
endtask
task meas_in(input logic signed [15:0] qq, input logic [15:0] ii, aa, vv);
    qr <= qq;
    ic <= ii;
    ang <= aa;
    vab <= vv;
    vbc <= vv;
    vca <= vv;
endtask
// Edges counted until output k is seen high, at most lim
task meas(input integer k, input integer lim);
    n = 0;
    do begin
        @(posedge sys_clk);
        n++;
    end while (n < lim && outs[k] !== 1'b1);
endtask
task do_reset(input integer cy);
    rst <= 1'b1;
    repeat (cy) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
endtask
// Pickup expected from control bits and measurements at reset thresholds
function logic pick(input logic [3:0] cc, input logic signed [15:0] qq,
    input logic [15:0] ii, aa, vv);
    logic dem;
    dem = cc[1] ? (qq < -$signed(`RST_QMIN)) : (qq < 0 && aa > `RST_ANGLE_LIM);
    return cc[0] && vv < `RST_UV_LIM && dem &&
        (ii > `RST_IMIN || (cc[1] && !cc[2]));
endfunction
// ------------------------------------------------------------
// Scenarios
// ------------------------------------------------------------
initial begin
    exp_tab = '{`RST_CTRL, `RST_ANGLE_LIM, `RST_IMIN, `RST_QMIN,
        `RST_UV_LIM, `RST_VREL, `RST_FMIN, `RST_FMAX, `RST_TRIG_MASK,
        16'h0, 16'h0};
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_address <= 8'h0;
    avs_writedata <= 32'h0;
    avs_byteenable <= 4'hf;
    grant <= 1'b0;
    fr <= 16'hc350;
    trip_in <= 16'h0;
    meas_in(16'sd0, 16'h0, 16'h0, 16'h400);
    do_reset(20);
    for (k = 0; k < 11; k++)
        rchk(8'(k * 4), {16'h0, exp_tab[k]});
    bus(1'b1, `ADDR_STATUS, 32'hff);
    rchk(`ADDR_STATUS, 32'h0);
    bus(1'b1, `ADDR_QMIN, 32'h1234_0040);
    rchk(`ADDR_QMIN, 32'h40);
    // Random settings and measurements, thresholds back at reset values
    for (k = 0; k < 14; k++) begin
        do_reset(2);
        c = 4'($random(seed)) & 4'h7;
        q = ($random(seed) & 1) ? -16'sd256 : 16'sd256;
        i = ($random(seed) & 1) ? 16'h200 : 16'h20;
        a = ($random(seed) & 1) ? 16'h80 : 16'h10;
        v = ($random(seed) & 1) ? 16'h300 : 16'h3f0;
        bus(1'b1, `ADDR_CTRL, {28'h0, c});
        meas_in(q, i, a, v);
        meas(0, T1 + 4);
        chk(n, pick(c, q, i, a, v) ? T1 + 2 : T1 + 4, "unit delay");
        vab <= 16'h400;
        repeat (2) @(posedge sys_clk);
        chk(unit_trip, 1'b0, "trip clear");
    end
    // Short dropout restarts both timers, then the PCC breaker trips
    do_reset(2);
    bus(1'b1, `ADDR_CTRL, 32'h3);
    meas_in(-16'sd256, 16'h200, 16'h80, 16'h300);
    repeat (10) @(posedge sys_clk);
    vab <= 16'h400;
    @(posedge sys_clk);
    vab <= 16'h300;
    meas(0, T2 + 4);
    chk(n, T1 + 2, "restart");
    meas(1, T2 + 4);
    chk(n, T2 - T1, "pcc trip");
    meas_in(16'sd0, 16'h200, 16'h0, 16'h400);
    meas(2, TR + 20);
    chk(reclose_release, 1'b0, "pcc inhibit");
    // Internal release: other trips alone, then frequency and voltage
    do_reset(2);
    bus(1'b1, `ADDR_CTRL, 32'h3);
    trip_in <= 16'h1 << ($random(seed) & 15);
    repeat (3) @(posedge sys_clk);
    trip_in <= 16'h0;
    meas(2, TR + 10);
    chk(reclose_release, 1'b0, "no gen trip");
    meas_in(-16'sd256, 16'h200, 16'h80, 16'h300);
    repeat (T1 + 5) @(posedge sys_clk);
    meas_in(16'sd0, 16'h200, 16'h0, 16'h3e0 + (16'($random(seed)) & 16'h1f));
    fr <= 16'hc738;
    meas(2, TR + 10);
    chk(reclose_release, 1'b0, "freq high");
    fr <= 16'hc350;
    vca <= 16'h3c0;
    repeat (4) @(posedge sys_clk);
    chk(reclose_release, 1'b0, "phase low");
    vca <= 16'h400;
    meas(2, 6);
    chk(reclose_release, 1'b1, "release");
    trip_in <= 16'h8000;
    repeat (3) @(posedge sys_clk);
    chk(reclose_release, 1'b0, "other trip");
    trip_in <= 16'h0;
    // External release follows the station, not the measured voltage
    do_reset(2);
    bus(1'b1, `ADDR_CTRL, 32'hb);
    meas_in(-16'sd256, 16'h200, 16'h80, 16'h300);
    repeat (T1 + 5) @(posedge sys_clk);
    meas_in(16'sd0, 16'h200, 16'h0, 16'h300);
    meas(2, TR + 10);
    chk(reclose_release, 1'b0, "no grant");
    grant <= 1'b1;
    meas(2, 20);
    chk(reclose_release, 1'b1, "grant");
    results();
end
endmodule // reactive_undervoltage_decoupling_test
bind reactive_undervoltage_decoupling qv_decoupling_assertions #(
    .T1_CYC(T1_CYC), .T2_CYC(T2_CYC), .TREC_CYC(TREC_CYC),
    .TRIG_W(TRIG_W)) u_chk (.sys_clk(sys_clk), .rst(rst),
    .ext_trip_in(ext_trip_in), .unit_trip(unit_trip),
    .pcc_trip(pcc_trip), .reclose_release(reclose_release));
